/* File: pwc_map.vh */
// Constants for the polling and wake-up control block.
`ifndef PWC_MAP_VH
`define PWC_MAP_VH

// Base tick divider: crystal periods per base tick for each level of the mode pin.
`define PWC_DIV_MODE_L        4'ha
`define PWC_DIV_MODE_H        4'he
`define PWC_DIV_W             4

// Base tick periods for the two reference crystals, in picoseconds.
`define PWC_TCLK_MODE_L_PS    2038300
`define PWC_TCLK_MODE_H_PS    2069700

// Extended tick lengths in base ticks, one per baud range.
`define PWC_EXT_LEN_R0        4'h8
`define PWC_EXT_LEN_R1        4'h4
`define PWC_EXT_LEN_R2        4'h2
`define PWC_EXT_LEN_R3        4'h1
`define PWC_EXT_W             4

// Sleep interval: sleep field times extension factor times this shift of base ticks.
`define PWC_SLEEP_SHIFT       10
`define PWC_SLEEP_XSHIFT      3
`define PWC_SLEEP_W           18
`define PWC_SLEEP_MAX         5'h1f

// Start-up settling time in base ticks.
`define PWC_STARTUP_TICKS     10'h0c8
`define PWC_STARTUP_W         10

// Bit-check configuration and limit counter.
`define PWC_NBITS_0           4'h0
`define PWC_NBITS_1           4'h3
`define PWC_NBITS_2           4'h6
`define PWC_NBITS_3           4'h9
`define PWC_CHECK_W           5
`define PWC_LIM_W             6
`define PWC_LIM_SAT           6'h3f

// Phase codes shown on the phase output.
`define PWC_PH_SLEEP          2'h0
`define PWC_PH_STARTUP        2'h1
`define PWC_PH_CHECK          2'h2
`define PWC_PH_RECEIVE        2'h3

`endif

/* File: pwc_tick_gen.v */
// Base tick and extended tick generator for the polling control block.
`timescale 1ns/10ps
`include "pwc_map.vh"

module pwc_tick_gen (
    input  wire       clk,
    input  wire       rst_n,
    input  wire       mode_sel,
    input  wire [1:0] baud_range_select,
    output reg        base_tick_r,
    output reg        extended_tick_r
);

    reg  [`PWC_DIV_W-1:0] div_cnt_r;
    reg  [`PWC_EXT_W-1:0] ext_cnt_r;
    wire [`PWC_DIV_W-1:0] div_last;
    reg  [`PWC_EXT_W-1:0] ext_last;
    wire                  base_now;

    // The mode pin picks the crystal division factor.
    assign div_last = mode_sel ? (`PWC_DIV_MODE_H - 4'h1) : (`PWC_DIV_MODE_L - 4'h1);
    assign base_now = (div_cnt_r >= div_last);

    always @* begin
        case (baud_range_select)
            2'h0:    ext_last = `PWC_EXT_LEN_R0 - 4'h1;
            2'h1:    ext_last = `PWC_EXT_LEN_R1 - 4'h1;
            2'h2:    ext_last = `PWC_EXT_LEN_R2 - 4'h1;
            default: ext_last = `PWC_EXT_LEN_R3 - 4'h1;
        endcase
    end

    always @(posedge clk) begin
        if (!rst_n) begin
            div_cnt_r       <= {`PWC_DIV_W{1'b0}};
            ext_cnt_r       <= {`PWC_EXT_W{1'b0}};
            base_tick_r     <= 1'b0;
            extended_tick_r <= 1'b0;
        end else begin
            // Comparing with >= lets a mode change mid-period finish cleanly.
            div_cnt_r   <= base_now ? {`PWC_DIV_W{1'b0}} : div_cnt_r + 4'h1;
            base_tick_r <= base_now;
            extended_tick_r <= 1'b0;
            if (base_now) begin
                if (ext_cnt_r >= ext_last) begin
                    ext_cnt_r       <= {`PWC_EXT_W{1'b0}};
                    extended_tick_r <= 1'b1;
                end else begin
                    ext_cnt_r <= ext_cnt_r + 4'h1;
                end
            end
        end
    end

endmodule

/* File: pwc_polling_ctrl.v */
// Polling and wake-up control of a low-power receiver: sleep, start-up, bit check, receive.
// Function
// - Filter corner follows selected baud range.
// - All timing derives from one base tick.
// - Mode pin picks crystal division factor.
// - Division gives about 2.04 or 2.07 us.
// - Extended tick is 8,4,2,1 base ticks.
// - Loop sleep, start-up, bit check while polling.
// - Signal path disabled during sleep interval.
// - Start-up enables and settles signal path.
// - Failed bit check returns to sleep.
// - Stay active only after valid signal.
// - Indicator pin shows sleep or active.
// - Sleep lasts field times factor times 1024.
// - Extension factor 1, or 8 when selected.
// - Highest sleep value sleeps until reprogrammed.
// - Host pin switches receiver on and off.
// - Host configures polling parameters except the fixed start-up time.
// - Bits checked selectable 0,3,6,9, two edges each.
// - Edge time outside window ends check.
// - Receive mode held until explicit return.
`timescale 1ns/10ps
`include "pwc_map.vh"

module pwc_polling_ctrl (
    input  wire       CLOCK,
    input  wire       RST_N,
    input  wire       MODE_SEL,
    input  wire [1:0] BAUD_RANGE_SELECT,
    input  wire [4:0] SLEEP_VALUE,
    input  wire       SLEEP_EXTENSION_SELECT,
    input  wire [1:0] BIT_CHECK_COUNT,
    input  wire [5:0] LIM_MIN,
    input  wire [5:0] LIM_MAX,
    input  wire       RX_ON_N,
    input  wire       RETURN_TO_POLLING,
    input  wire       DEMOD_IN,
    output reg  [1:0] FILTER_CORNER,
    output reg        ACTIVITY_INDICATOR,
    output reg        SIGNAL_ENABLE,
    output reg        RECEIVING,
    output reg        DATA_OUT,
    output reg  [1:0] PHASE,
    output reg        BASE_TICK,
    output reg        EXTENDED_TICK
);

    localparam [1:0] ST_SLEEP   = 2'h0;
    localparam [1:0] ST_STARTUP = 2'h1;
    localparam [1:0] ST_CHECK   = 2'h2;
    localparam [1:0] ST_RECEIVE = 2'h3;

    wire base_tick;
    wire extended_tick;

    reg  [1:0]                  state_r;
    reg  [1:0]                  state_nxt;
    reg  [`PWC_SLEEP_W-1:0]     sleep_cnt_r;
    reg  [`PWC_SLEEP_W-1:0]     sleep_cnt_nxt;
    reg  [`PWC_STARTUP_W-1:0]   startup_cnt_r;
    reg  [`PWC_STARTUP_W-1:0]   startup_cnt_nxt;
    reg  [`PWC_LIM_W-1:0]       cv_lim_r;
    reg  [`PWC_LIM_W-1:0]       cv_lim_nxt;
    reg  [`PWC_CHECK_W-1:0]     checks_r;
    reg  [`PWC_CHECK_W-1:0]     checks_nxt;
    reg                         first_edge_r;
    reg                         first_edge_nxt;
    reg  [4:0]                  sleep_prev_r;
    reg                         rx_on_prev_r;
    reg                         data_sync_r;
    reg                         data_sync_nxt;

    wire                        sleep_changed;
    wire                        permanent_sleep;
    wire                        edge_seen;
    wire [`PWC_LIM_W-1:0]       cv_step;
    wire [`PWC_CHECK_W-1:0]     checks_needed;
    wire                        window_ok;
    wire                        window_expired;
    wire                        host_off_release;

    // Sleep interval in base ticks: field times extension factor times 1024.
    function [`PWC_SLEEP_W-1:0] sleep_load;
        input [4:0] field;
        input       ext_sel;
        reg   [`PWC_SLEEP_W-1:0] base;
        begin
            base = {{(`PWC_SLEEP_W-15){1'b0}}, field, {`PWC_SLEEP_SHIFT{1'b0}}};
            if (ext_sel) begin
                sleep_load = base << `PWC_SLEEP_XSHIFT;
            end else begin
                sleep_load = base;
            end
        end
    endfunction

    // Edge-to-edge checks needed: two per requested bit.
    function [`PWC_CHECK_W-1:0] edge_checks;
        input [1:0] sel;
        reg   [3:0] bits;
        begin
            case (sel)
                2'h0:    bits = `PWC_NBITS_0;
                2'h1:    bits = `PWC_NBITS_1;
                2'h2:    bits = `PWC_NBITS_2;
                default: bits = `PWC_NBITS_3;
            endcase
            edge_checks = {bits, 1'b0};
        end
    endfunction

    function [1:0] phase_code;
        input [1:0] st;
        begin
            case (st)
                ST_SLEEP:   phase_code = `PWC_PH_SLEEP;
                ST_STARTUP: phase_code = `PWC_PH_STARTUP;
                ST_CHECK:   phase_code = `PWC_PH_CHECK;
                default:    phase_code = `PWC_PH_RECEIVE;
            endcase
        end
    endfunction

    pwc_tick_gen u_tick (
        .clk               (CLOCK),
        .rst_n             (RST_N),
        .mode_sel          (MODE_SEL),
        .baud_range_select (BAUD_RANGE_SELECT),
        .base_tick_r       (base_tick),
        .extended_tick_r   (extended_tick)
    );

    assign sleep_changed   = (SLEEP_VALUE != sleep_prev_r);
    assign permanent_sleep = (SLEEP_VALUE == `PWC_SLEEP_MAX);
    assign checks_needed   = edge_checks(BIT_CHECK_COUNT);
    // Demodulator output is only looked at on extended ticks, which debounces it.
    assign edge_seen       = extended_tick && (DEMOD_IN != data_sync_r);
    assign cv_step         = (cv_lim_r == `PWC_LIM_SAT) ? cv_lim_r : cv_lim_r + 6'h01;
    assign window_ok       = (cv_step >= LIM_MIN) && (cv_step < LIM_MAX);
    assign window_expired  = (cv_step >= LIM_MAX);
    assign host_off_release = RX_ON_N && !rx_on_prev_r;

    always @* begin
        state_nxt       = state_r;
        sleep_cnt_nxt   = sleep_cnt_r;
        startup_cnt_nxt = startup_cnt_r;
        cv_lim_nxt      = cv_lim_r;
        checks_nxt      = checks_r;
        first_edge_nxt  = first_edge_r;
        data_sync_nxt   = data_sync_r;

        if (extended_tick) begin
            data_sync_nxt = DEMOD_IN;
        end

        case (state_r)
            ST_SLEEP: begin
                // Signal path stays off for the whole interval.
                if (sleep_changed) begin
                    sleep_cnt_nxt = sleep_load(SLEEP_VALUE, SLEEP_EXTENSION_SELECT);
                end else if (permanent_sleep) begin
                    sleep_cnt_nxt = sleep_cnt_r;
                end else if (sleep_cnt_r == {`PWC_SLEEP_W{1'b0}}) begin
                    state_nxt       = ST_STARTUP;
                    startup_cnt_nxt = `PWC_STARTUP_TICKS;
                end else if (base_tick) begin
                    sleep_cnt_nxt = sleep_cnt_r - 18'h00001;
                end
            end
            ST_STARTUP: begin
                if (startup_cnt_r == {`PWC_STARTUP_W{1'b0}}) begin
                    state_nxt      = ST_CHECK;
                    cv_lim_nxt     = {`PWC_LIM_W{1'b0}};
                    checks_nxt     = {`PWC_CHECK_W{1'b0}};
                    first_edge_nxt = 1'b0;
                end else if (base_tick) begin
                    startup_cnt_nxt = startup_cnt_r - 10'h001;
                end
            end
            ST_CHECK: begin
                if (checks_r >= checks_needed) begin
                    state_nxt = ST_RECEIVE;
                end else if (extended_tick) begin
                    if (edge_seen) begin
                        cv_lim_nxt     = {`PWC_LIM_W{1'b0}};
                        first_edge_nxt = 1'b1;
                        // The first edge only starts timing; the one before it is unknown.
                        if (first_edge_r) begin
                            if (window_ok) begin
                                checks_nxt = checks_r + 5'h01;
                            end else begin
                                state_nxt = ST_SLEEP;
                            end
                        end
                    end else if (window_expired) begin
                        state_nxt = ST_SLEEP;
                    end else begin
                        cv_lim_nxt = cv_step;
                    end
                end
            end
            default: begin
                if (RETURN_TO_POLLING) begin
                    state_nxt = ST_SLEEP;
                end
            end
        endcase

        if (state_r != ST_SLEEP && state_nxt == ST_SLEEP) begin
            sleep_cnt_nxt = sleep_load(SLEEP_VALUE, SLEEP_EXTENSION_SELECT);
        end

        // The host pin overrides the polling loop in both directions.
        if (!RX_ON_N) begin
            state_nxt = ST_RECEIVE;
        end else if (host_off_release) begin
            state_nxt     = ST_SLEEP;
            sleep_cnt_nxt = sleep_load(SLEEP_VALUE, SLEEP_EXTENSION_SELECT);
        end
    end

    always @(posedge CLOCK) begin
        if (!RST_N) begin
            state_r       <= ST_SLEEP;
            sleep_cnt_r   <= {`PWC_SLEEP_W{1'b0}};
            startup_cnt_r <= {`PWC_STARTUP_W{1'b0}};
            cv_lim_r      <= {`PWC_LIM_W{1'b0}};
            checks_r      <= {`PWC_CHECK_W{1'b0}};
            first_edge_r  <= 1'b0;
            sleep_prev_r  <= 5'h00;
            rx_on_prev_r  <= 1'b1;
            data_sync_r   <= 1'b1;
        end else begin
            state_r       <= state_nxt;
            sleep_cnt_r   <= sleep_cnt_nxt;
            startup_cnt_r <= startup_cnt_nxt;
            cv_lim_r      <= cv_lim_nxt;
            checks_r      <= checks_nxt;
            first_edge_r  <= first_edge_nxt;
            sleep_prev_r  <= SLEEP_VALUE;
            rx_on_prev_r  <= RX_ON_N;
            data_sync_r   <= data_sync_nxt;
        end
    end

    // Phase, indicator, enable, receiving and data outputs are registered from the next state so they track the phase without lag.
    always @(posedge CLOCK) begin
        if (!RST_N) begin
            FILTER_CORNER      <= 2'h0;
            ACTIVITY_INDICATOR <= 1'b0;
            SIGNAL_ENABLE      <= 1'b0;
            RECEIVING          <= 1'b0;
            DATA_OUT           <= 1'b1;
            PHASE              <= `PWC_PH_SLEEP;
            BASE_TICK          <= 1'b0;
            EXTENDED_TICK      <= 1'b0;
        end else begin
            FILTER_CORNER      <= BAUD_RANGE_SELECT;
            ACTIVITY_INDICATOR <= (state_nxt != ST_SLEEP);
            SIGNAL_ENABLE      <= (state_nxt != ST_SLEEP);
            RECEIVING          <= (state_nxt == ST_RECEIVE);
            // Data reaches the host only in receive mode; idle level is high otherwise.
            DATA_OUT           <= (state_nxt == ST_RECEIVE) ? data_sync_nxt : 1'b1;
            PHASE              <= phase_code(state_nxt);
            BASE_TICK          <= base_tick;
            EXTENDED_TICK      <= extended_tick;
        end
    end

endmodule

/* File: pwc_ctrl_chk_asserts.sv */
// Port-level assertion checker for the polling and wake-up control block.
`timescale 1ns/10ps
module pwc_ctrl_chk (
    input logic       CLOCK,
    input logic       RST_N,
    input logic [1:0] BAUD_RANGE_SELECT,
    input logic [4:0] SLEEP_VALUE,
    input logic       RX_ON_N,
    input logic       RETURN_TO_POLLING,
    input logic [1:0] FILTER_CORNER,
    input logic       ACTIVITY_INDICATOR,
    input logic       SIGNAL_ENABLE,
    input logic       RECEIVING,
    input logic       DATA_OUT,
    input logic [1:0] PHASE,
    input logic       BASE_TICK,
    input logic       EXTENDED_TICK
);
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RST_N);
    // Outputs from the cycle right after reset still show reset values, so skip that edge.
    sequence s_live;
        RST_N && $past(RST_N);
    endsequence
    sequence s_ret;
        RECEIVING && RETURN_TO_POLLING && RX_ON_N;
    endsequence
    sequence s_gone;
        !RECEIVING && !ACTIVITY_INDICATOR && PHASE == 2'h0;
    endsequence
    property p_corner; s_live |-> FILTER_CORNER == $past(BAUD_RANGE_SELECT); endproperty
    a_corner: assert property (p_corner) else $error("filter corner not following range");
    property p_ind; s_live |-> ACTIVITY_INDICATOR == (PHASE != 2'h0); endproperty
    a_ind: assert property (p_ind) else $error("indicator disagrees with phase");
    property p_en; SIGNAL_ENABLE == ACTIVITY_INDICATOR; endproperty
    a_en: assert property (p_en) else $error("signal path enable wrong");
    property p_base; BASE_TICK |=> !BASE_TICK [*8]; endproperty
    a_base: assert property (p_base) else $error("base tick too close");
    property p_ext; EXTENDED_TICK |-> BASE_TICK; endproperty
    a_ext: assert property (p_ext) else $error("extended tick off base grid");
    property p_order;
        s_live ##0 (PHASE != $past(PHASE) && RX_ON_N && $past(RX_ON_N))
            |-> PHASE == $past(PHASE) + 2'h1 || PHASE == 2'h0;
    endproperty
    a_order: assert property (p_order) else $error("phase order broken");
    property p_rx; s_live |-> RECEIVING == (PHASE == 2'h3); endproperty
    a_rx: assert property (p_rx) else $error("receiving flag disagrees with phase");
    property p_ret; s_ret |=> s_gone; endproperty
    a_ret: assert property (p_ret) else $error("return to polling not taken");
    property p_on; !RX_ON_N |=> RECEIVING; endproperty
    a_on: assert property (p_on) else $error("host on pin not followed");
    property p_perm;
        PHASE == 2'h0 && RX_ON_N && SLEEP_VALUE == 5'h1f && $past(SLEEP_VALUE) == 5'h1f
            && $past(SLEEP_VALUE, 2) == 5'h1f |=> PHASE == 2'h0;
    endproperty
    a_perm: assert property (p_perm) else $error("left permanent sleep");
    property p_dout; !RECEIVING && !$past(RECEIVING) |-> DATA_OUT; endproperty
    a_dout: assert property (p_dout) else $error("data passed while not receiving");
endmodule
bind pwc_polling_ctrl pwc_ctrl_chk pwc_ctrl_chk_i (.CLOCK(CLOCK), .RST_N(RST_N),
    .BAUD_RANGE_SELECT(BAUD_RANGE_SELECT), .SLEEP_VALUE(SLEEP_VALUE), .RX_ON_N(RX_ON_N),
    .RETURN_TO_POLLING(RETURN_TO_POLLING), .FILTER_CORNER(FILTER_CORNER),
    .ACTIVITY_INDICATOR(ACTIVITY_INDICATOR), .SIGNAL_ENABLE(SIGNAL_ENABLE),
    .RECEIVING(RECEIVING), .DATA_OUT(DATA_OUT), .PHASE(PHASE), .BASE_TICK(BASE_TICK),
    .EXTENDED_TICK(EXTENDED_TICK));

/* File: pwc_host_model.sv */
// Transmitter and host side model driving the demodulated data line.
`timescale 1ns/10ps
module pwc_host_model (
    input  wire        clk,
    input  wire [15:0] gap,
    output reg         demod
);
    reg [15:0] cnt_r;
    initial begin
        demod = 1'b1;
        cnt_r = 16'h0000;
    end
    // A zero gap holds the line; otherwise a steady preburst toggles every gap clocks.
    always @(negedge clk) begin
        if (gap == 16'h0000) begin
            cnt_r <= 16'h0000;
        end else if (cnt_r + 16'h0001 >= gap) begin
            cnt_r <= 16'h0000;
            demod <= ~demod;
        end else begin
            cnt_r <= cnt_r + 16'h0001;
        end
    end
endmodule

/* File: testbench.sv */
// Self-checking bench for the polling and wake-up control block.
`timescale 1ns/10ps
module testbench;
    reg         CLOCK = 1'b0;
    reg         RST_N = 1'b0;
    reg         MODE_SEL = 1'b0;
    reg  [1:0]  BAUD_RANGE_SELECT = 2'h3;
    reg  [4:0]  SLEEP_VALUE = 5'h1f;
    reg  [1:0]  BIT_CHECK_COUNT = 2'h1;
    reg         RX_ON_N = 1'b1;
    reg         RETURN_TO_POLLING = 1'b0;
    reg         SLEEP_EXTENSION_SELECT = 1'b0;
    reg  [15:0] gap = 16'h0000;
    reg         which = 1'b0;
    reg  [10:0] rows [0:7];
    wire        DEMOD_IN;
    wire [1:0]  FILTER_CORNER;
    wire [1:0]  PHASE;
    wire        ACTIVITY_INDICATOR;
    wire        SIGNAL_ENABLE;
    wire        RECEIVING;
    wire        DATA_OUT;
    wire        BASE_TICK;
    wire        EXTENDED_TICK;
    wire        pick = which ? EXTENDED_TICK : BASE_TICK;
    integer     bad_count = 0;
    integer     samples_checked = 0;
    integer     n;
    integer     i;
    always #50 CLOCK = ~CLOCK;
    pwc_host_model pwc_host_model_i (.clk(CLOCK), .gap(gap), .demod(DEMOD_IN));
    pwc_polling_ctrl pwc_polling_ctrl_i (.CLOCK(CLOCK), .RST_N(RST_N), .MODE_SEL(MODE_SEL),
        .BAUD_RANGE_SELECT(BAUD_RANGE_SELECT), .SLEEP_VALUE(SLEEP_VALUE),
        .SLEEP_EXTENSION_SELECT(SLEEP_EXTENSION_SELECT), .BIT_CHECK_COUNT(BIT_CHECK_COUNT),
        .LIM_MIN(6'h04), .LIM_MAX(6'h08), .RX_ON_N(RX_ON_N),
        .RETURN_TO_POLLING(RETURN_TO_POLLING), .DEMOD_IN(DEMOD_IN),
        .FILTER_CORNER(FILTER_CORNER), .ACTIVITY_INDICATOR(ACTIVITY_INDICATOR),
        .SIGNAL_ENABLE(SIGNAL_ENABLE), .RECEIVING(RECEIVING), .DATA_OUT(DATA_OUT), .PHASE(PHASE),
        .BASE_TICK(BASE_TICK), .EXTENDED_TICK(EXTENDED_TICK));
    task close_out;
        begin
            if (bad_count == 0 && samples_checked > 0) begin
                $display("All tests passed");
            end else begin
                $display("Some tests failed");
            end
            $finish;
        end
    endtask
    task chk(input [17:0] seen, input [17:0] exp);
        begin
            samples_checked = samples_checked + 1;
            if (seen !== exp) begin
                bad_count = bad_count + 1;
                $display("[FAIL] %0t seen %0h expected %0h", $time, seen, exp);
            end
        end
    endtask
    task hang;
        begin
            bad_count = bad_count + 1;
            $display("[FAIL] %0t wait ran out", $time);
            close_out;
        end
    endtask
    // Clocks between two pulses of the picked tick.
    task span(output integer p);
        begin
            p = 0;
            @(negedge CLOCK);
            while (pick !== 1'b1 && p < 300) begin
                @(negedge CLOCK);
                p = p + 1;
            end
            if (p >= 300) hang;
            p = 1;
            @(negedge CLOCK);
            while (pick !== 1'b1 && p < 300) begin
                @(negedge CLOCK);
                p = p + 1;
            end
            if (p >= 300) hang;
        end
    endtask
    task wait_ph(input [1:0] ph, input integer lim, output integer c);
        begin
            c = 0;
            while (PHASE !== ph && c < lim) begin
                @(negedge CLOCK);
                c = c + 1;
            end
            if (c >= lim) hang;
        end
    endtask
    // Waits for the demodulated line to reach a level, noticed at most one clock late.
    task wait_line(input v);
        begin
            n = 0;
            while (DEMOD_IN !== v && n < 200) begin
                @(negedge CLOCK);
                n = n + 1;
            end
            if (n >= 200) hang;
        end
    endtask
    initial begin
        rows[0] = 11'h050;
        rows[1] = 11'h128;
        rows[2] = 11'h214;
        rows[3] = 11'h30a;
        rows[4] = 11'h470;
        rows[5] = 11'h538;
        rows[6] = 11'h61c;
        rows[7] = 11'h70e;
        repeat (8) @(negedge CLOCK);
        RST_N = 1'b1;
        @(negedge CLOCK);
        chk({PHASE, RECEIVING, DATA_OUT, ACTIVITY_INDICATOR, SIGNAL_ENABLE}, 18'h00004);
        for (i = 0; i < 8; i = i + 1) begin
            {MODE_SEL, BAUD_RANGE_SELECT} = rows[i][10:8];
            which = 1'b0;
            span(n);
            span(n);
            chk(n, MODE_SEL ? 18'h0000e : 18'h0000a);
            which = 1'b1;
            span(n);
            span(n);
            chk(n, {10'h000, rows[i][7:0]});
            chk(FILTER_CORNER, BAUD_RANGE_SELECT);
            chk(PHASE, 2'h0);
        end
        MODE_SEL = 1'b0;
        BAUD_RANGE_SELECT = 2'h3;
        BIT_CHECK_COUNT = 2'h3;
        gap = 16'h003c;
        SLEEP_VALUE = 5'h01;
        wait_ph(2'h1, 10300, n);
        chk(n >= 10230 && n <= 10260, 1'b1);
        chk({SIGNAL_ENABLE, ACTIVITY_INDICATOR}, 2'h3);
        wait_ph(2'h2, 2100, n);
        chk(n >= 1990 && n <= 2010, 1'b1);
        // Eighteen checks six ticks apart, after one untimed first edge.
        wait_ph(2'h3, 1300, n);
        chk(n >= 1075 && n <= 1160, 1'b1);
        repeat (20) @(negedge CLOCK);
        chk({PHASE, RECEIVING, ACTIVITY_INDICATOR, SIGNAL_ENABLE}, 18'h0001f);
        wait_line(1'b1);
        wait_line(1'b0);
        repeat (30) @(negedge CLOCK);
        chk(DATA_OUT, 1'b0);
        wait_line(1'b1);
        repeat (30) @(negedge CLOCK);
        chk(DATA_OUT, 1'b1);
        SLEEP_EXTENSION_SELECT = 1'b1;
        RETURN_TO_POLLING = 1'b1;
        @(negedge CLOCK);
        RETURN_TO_POLLING = 1'b0;
        gap = 16'h0014;
        @(negedge CLOCK);
        chk({PHASE, RECEIVING, ACTIVITY_INDICATOR, SIGNAL_ENABLE}, 18'h00000);
        wait_ph(2'h1, 82000, n);
        chk(n >= 81900 && n <= 81940, 1'b1);
        // Edges two ticks apart fall below the lower window limit, so the check must fail.
        wait_ph(2'h2, 2100, n);
        wait_ph(2'h0, 300, n);
        chk(RECEIVING, 1'b0);
        SLEEP_EXTENSION_SELECT = 1'b0;
        SLEEP_VALUE = 5'h00;
        BIT_CHECK_COUNT = 2'h0;
        wait_ph(2'h2, 2100, n);
        wait_ph(2'h3, 3, n);
        RX_ON_N = 1'b0;
        RETURN_TO_POLLING = 1'b1;
        repeat (3) @(negedge CLOCK);
        chk(PHASE, 2'h3);
        RETURN_TO_POLLING = 1'b0;
        RX_ON_N = 1'b1;
        wait_ph(2'h0, 4, n);
        RX_ON_N = 1'b0;
        wait_ph(2'h3, 4, n);
        RX_ON_N = 1'b1;
        wait_ph(2'h0, 4, n);
        // A reset in mid-run, taken from an active phase, must bring the phase, receiving, data, indicator and enable outputs to idle.
        repeat (3) @(negedge CLOCK);
        RST_N = 1'b0;
        repeat (2) @(negedge CLOCK);
        chk({PHASE, RECEIVING, DATA_OUT, ACTIVITY_INDICATOR, SIGNAL_ENABLE}, 18'h00004);
        RST_N = 1'b1;
        repeat (3) @(negedge CLOCK);
        close_out;
    end
endmodule
